// >>> hdl/slic_input_irq.sv
// Purpose: eight-channel line-interface input debounce and change interrupts
// Assumes: APB slave, one wait state on every access; pins are asynchronous
// Notes: per-channel status read clears that channel's pending bits
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module slic_input_irq #(
    parameter int LIM_W = 5
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_frame_sync_strobe,
    input wire logic [slic_pkg::NUM_CH-1:0] i_hook_input,
    input wire logic [slic_pkg::NUM_CH-1:0] i_ground_key_input,
    input wire logic [slic_pkg::NUM_CH-1:0] i_bidir_pin_a,
    output logic [slic_pkg::NUM_CH-1:0] o_bidir_pin_a,
    output logic [slic_pkg::NUM_CH-1:0] o_bidir_pin_a_oe,
    input wire logic [slic_pkg::NUM_CH-1:0] i_bidir_pin_b,
    output logic [slic_pkg::NUM_CH-1:0] o_bidir_pin_b,
    output logic [slic_pkg::NUM_CH-1:0] o_bidir_pin_b_oe,
    output logic [slic_pkg::NUM_CH-1:0] o_debounced_hook_bit,
    output logic [slic_pkg::NUM_CH-1:0] o_debounced_ground_key_bit,
    output logic o_irq
);
    import slic_pkg::*;

    localparam int NSRC = NUM_CH * SRC_PER_CH;

    // two-stage synchronisers, third stage only for edge detection
    logic fs_s1, fs_s2, fs_s3;
    logic [NUM_CH-1:0] hook_s1, hook_s2;
    logic [NUM_CH-1:0] gk_s1, gk_s2;
    logic [NUM_CH-1:0] pa_s1, pa_s2, pa_s3;
    logic [NUM_CH-1:0] pb_s1, pb_s2, pb_s3;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            {fs_s1, fs_s2, fs_s3} <= 3'h0;
            {hook_s1, hook_s2, gk_s1, gk_s2} <= '0;
            {pa_s1, pa_s2, pa_s3, pb_s1, pb_s2, pb_s3} <= '0;
        end else begin
            {fs_s1, fs_s2, fs_s3} <= {i_frame_sync_strobe, fs_s1, fs_s2};
            {hook_s1, hook_s2} <= {i_hook_input, hook_s1};
            {gk_s1, gk_s2} <= {i_ground_key_input, gk_s1};
            {pa_s1, pa_s2, pa_s3} <= {i_bidir_pin_a, pa_s1, pa_s2};
            {pb_s1, pb_s2, pb_s3} <= {i_bidir_pin_b, pb_s1, pb_s2};
        end
    end

    // frame-derived ticks shared by all channels
    logic fs_edge;
    logic [3:0] fr_cnt;
    logic samp_tick, step_tick, ms_tick;

    assign fs_edge = fs_s2 && !fs_s3;
    assign samp_tick = fs_edge && ((fr_cnt % 4'(FR_PER_SAMPLE)) == 4'(FR_PER_SAMPLE - 1));
    assign step_tick = fs_edge && (fr_cnt == 4'(FR_PER_STEP - 1));
    assign ms_tick = fs_edge && ((fr_cnt % 4'(FR_PER_MS)) == 4'(FR_PER_MS - 1));

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            fr_cnt <= 4'h0;
        end else if (fs_edge) begin
            fr_cnt <= fr_cnt + 4'h1; // wraps every 16 frames, one hook step
        end
    end

    // software registers
    logic [7:0] dir_a, dir_b, out_a, out_b;
    logic [NSRC-1:0] irq_en;
    logic [NUM_CH-1:0][LIM_W-1:0] hook_lim;
    logic [NUM_CH-1:0][LIM_W-1:0] gk_per;
    logic wr_en, rd_en;
    logic [2:0] ch_idx;
    logic is_ch_stat, is_ch_cfg;

    assign wr_en = i_psel && i_penable && i_pwrite && !o_pready;
    assign rd_en = i_psel && i_penable && !i_pwrite && !o_pready;
    assign ch_idx = i_paddr[4:2];
    assign is_ch_stat = (i_paddr[7:5] == CH_STAT_BASE) && (i_paddr[1:0] == 2'h0);
    assign is_ch_cfg = (i_paddr[7:5] == CH_CFG_BASE) && (i_paddr[1:0] == 2'h0);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            dir_a <= RST_DIR;
            dir_b <= RST_DIR;
            out_a <= RST_PIN_OUT;
            out_b <= RST_PIN_OUT;
            irq_en <= RST_IRQ_EN;
        end else if (wr_en) begin
            if (i_paddr == OFF_DIR_A) begin
                dir_a <= i_pwdata[7:0];
            end else if (i_paddr == OFF_DIR_B) begin
                dir_b <= i_pwdata[7:0];
            end else if (i_paddr == OFF_PIN_OUT) begin
                out_a <= i_pwdata[7:0];
                out_b <= i_pwdata[15:8];
            end else if (i_paddr == OFF_IRQ_EN) begin
                irq_en <= i_pwdata;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hook_lim <= {NUM_CH{RST_HOOK_LIMIT}};
            gk_per <= {NUM_CH{RST_GK_PERIOD}};
        end else if (wr_en && is_ch_cfg) begin
            hook_lim[ch_idx] <= i_pwdata[CFG_HOOK_LSB +: LIM_W];
            gk_per[ch_idx] <= i_pwdata[CFG_GK_LSB +: LIM_W];
        end
    end

    // per-channel filters and change events
    logic [NUM_CH-1:0] hook_deb, gk_deb, hook_prev, gk_prev;
    logic [NSRC-1:0] ev;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            slic_hook_filter #(.LIM_W(LIM_W)) u_hook_debounce_filter (
                .i_core_clk(i_core_clk),
                .i_rst(i_rst),
                .i_sample_tick(samp_tick),
                .i_step_tick(step_tick),
                .i_level(hook_s2[g]),
                .i_limit(hook_lim[g]),
                .o_state(hook_deb[g])
            );
            slic_gk_filter #(.PER_W(LIM_W)) u_ground_key_filter (
                .i_core_clk(i_core_clk),
                .i_rst(i_rst),
                .i_ms_tick(ms_tick),
                .i_level(gk_s2[g]),
                .i_period(gk_per[g]),
                .o_state(gk_deb[g])
            );
            assign ev[g*SRC_PER_CH + SRC_HOOK] = hook_deb[g] ^ hook_prev[g];
            assign ev[g*SRC_PER_CH + SRC_GK] = gk_deb[g] ^ gk_prev[g];
            // pins feed straight in, so a bouncing pin interrupts per bounce
            assign ev[g*SRC_PER_CH + SRC_PIN_A] = !dir_a[g] && (pa_s2[g] ^ pa_s3[g]);
            assign ev[g*SRC_PER_CH + SRC_PIN_B] = !dir_b[g] && (pb_s2[g] ^ pb_s3[g]);
        end
    endgenerate

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hook_prev <= '0;
            gk_prev <= '0;
        end else begin
            hook_prev <= hook_deb;
            gk_prev <= gk_deb;
        end
    end

    // pending bits: set beats the read-clear of the same cycle
    logic [NSRC-1:0] pend, clr_mask;

    always_comb begin
        clr_mask = '0;
        if (rd_en && is_ch_stat) begin
            clr_mask[ch_idx*SRC_PER_CH +: SRC_PER_CH] = '1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pend <= '0;
        end else begin
            pend <= (pend & ~clr_mask) | (ev & irq_en);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(pend & irq_en);
        end
    end

    // read data; the status snapshot and its clear share one edge
    logic [31:0] next_rdata;
    logic next_err;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (i_paddr == OFF_HOOK_STAT) begin
            next_rdata[7:0] = hook_deb;
        end else if (i_paddr == OFF_GK_STAT) begin
            next_rdata[7:0] = gk_deb;
        end else if (i_paddr == OFF_DIR_A) begin
            next_rdata[7:0] = dir_a;
        end else if (i_paddr == OFF_DIR_B) begin
            next_rdata[7:0] = dir_b;
        end else if (i_paddr == OFF_PIN_OUT) begin
            next_rdata[15:0] = {out_b, out_a};
        end else if (i_paddr == OFF_IRQ_EN) begin
            next_rdata = irq_en;
        end else if (i_paddr == OFF_IRQ_PEND) begin
            next_rdata = pend;
        end else if (is_ch_stat) begin
            next_rdata[SRC_HOOK] = hook_deb[ch_idx];
            next_rdata[SRC_GK] = gk_deb[ch_idx];
            next_rdata[SRC_PIN_A] = pa_s2[ch_idx];
            next_rdata[SRC_PIN_B] = pb_s2[ch_idx];
            next_rdata[STAT_PEND_LSB +: SRC_PER_CH] = pend[ch_idx*SRC_PER_CH +: SRC_PER_CH];
        end else if (is_ch_cfg) begin
            next_rdata[CFG_HOOK_LSB +: LIM_W] = hook_lim[ch_idx];
            next_rdata[CFG_GK_LSB +: LIM_W] = gk_per[ch_idx];
        end else begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready && next_err;
            if (rd_en) begin
                o_prdata <= next_rdata;
            end
        end
    end

    // pins and published debounced levels
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bidir_pin_a <= '0;
            o_bidir_pin_b <= '0;
            o_bidir_pin_a_oe <= '0;
            o_bidir_pin_b_oe <= '0;
            o_debounced_hook_bit <= '0;
            o_debounced_ground_key_bit <= '0;
        end else begin
            o_bidir_pin_a <= out_a;
            o_bidir_pin_b <= out_b;
            o_bidir_pin_a_oe <= dir_a;
            o_bidir_pin_b_oe <= dir_b;
            o_debounced_hook_bit <= hook_deb;
            o_debounced_ground_key_bit <= gk_deb;
        end
    end

    a_irq_follows_pend: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_irq == $past(|(pend & irq_en)))
        else $error("interrupt output does not track enabled pending");
    a_pend_needs_enable: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ((pend & ~$past(pend)) & ~$past(irq_en)) == '0)
        else $error("pending set for a disabled source");
    a_pend_clear_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (($past(pend) & ~pend) & ~$past(clr_mask)) == '0)
        else $error("pending cleared without channel status read");
    a_event_latched: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ((ev & irq_en) != '0) |=> ((pend & $past(ev & irq_en)) == $past(ev & irq_en)))
        else $error("enabled event lost");
    a_pin_out_silent: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ev[SRC_PIN_A] && dir_a[0]) == 1'b0)
        else $error("output pin raised an event");
    a_step_on_sample: assert property (@(posedge i_core_clk) disable iff (i_rst)
        step_tick |-> (samp_tick && ms_tick))
        else $error("step tick off the sample grid");
    a_hook_change_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (hook_deb != hook_prev) |-> $past(step_tick))
        else $error("hook level changed off a step tick");
    a_apb_one_wait: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_psel && i_penable && !o_pready) |=> (o_pready ##1 !o_pready))
        else $error("bus answer not after one wait state");
    a_err_with_ready: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_pslverr |-> o_pready)
        else $error("error response without ready");
    a_ready_one_cycle: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    a_unmapped_err: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_psel && i_penable && !o_pready && (i_paddr[1:0] != 2'h0)) |=> o_pslverr)
        else $error("unaligned address not refused");
    a_prdata_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !$past(rd_en) |-> $stable(o_prdata))
        else $error("read data moved without a read");
    a_dir_a_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_en && (i_paddr == OFF_DIR_A)) |=> (dir_a == $past(i_pwdata[7:0])))
        else $error("pin A direction write lost");
    // pin drivers and published levels are one register behind their source
    a_oe_a_dir: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_bidir_pin_a_oe == $past(dir_a))
        else $error("pin A enable does not follow direction");
    a_oe_b_dir: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_bidir_pin_b_oe == $past(dir_b))
        else $error("pin B enable does not follow direction");
    a_hook_copy: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_debounced_hook_bit == $past(hook_deb))
        else $error("published hook bits do not follow filter");
    a_gk_copy: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_debounced_ground_key_bit == $past(gk_deb))
        else $error("published ground-key bits do not follow filter");
    a_pin_b_silent: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ev[2*SRC_PER_CH + SRC_PIN_B] && dir_b[2]) == 1'b0)
        else $error("driven pin B raised an event");
    // a read with no new event in flight must leave the channel empty
    a_read_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (rd_en && is_ch_stat && ((ev & irq_en) == '0)) |=> ((pend & $past(clr_mask)) == '0))
        else $error("status read left pending bits");
    a_pend_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (clr_mask == '0) |=> ((pend & $past(pend)) == $past(pend)))
        else $error("pending bit dropped without a read");
    a_irq_idle_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ((pend & irq_en) == '0) |=> !o_irq)
        else $error("interrupt high with nothing pending");
endmodule // slic_input_irq
`default_nettype wire

// >>> hdl/slic_pkg.sv
// Purpose: shared constants of the line-interface input and interrupt block
// Assumes: 20 MHz core clock, frame sync strobe at 8 kHz
// Notes: all debounce timing is counted in frame sync periods
package slic_pkg;
    localparam int NUM_CH = 8;
    localparam int SRC_PER_CH = 4;
    localparam int SRC_HOOK = 0;
    localparam int SRC_GK = 1;
    localparam int SRC_PIN_A = 2;
    localparam int SRC_PIN_B = 3;

    // byte addresses on the register bus
    localparam logic [7:0] OFF_HOOK_STAT = 8'h00;
    localparam logic [7:0] OFF_GK_STAT = 8'h04;
    localparam logic [7:0] OFF_DIR_A = 8'h08;
    localparam logic [7:0] OFF_DIR_B = 8'h0C;
    localparam logic [7:0] OFF_PIN_OUT = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN = 8'h14;
    localparam logic [7:0] OFF_IRQ_PEND = 8'h18;
    localparam logic [2:0] CH_STAT_BASE = 3'h1;
    localparam logic [2:0] CH_CFG_BASE = 3'h2;

    // field positions
    localparam int CFG_HOOK_LSB = 0;
    localparam int CFG_GK_LSB = 8;
    localparam int STAT_PEND_LSB = 4;

    // values after reset
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_PIN_OUT = 8'h00;
    localparam logic [31:0] RST_IRQ_EN = 32'h0000_0000;
    localparam logic [4:0] RST_HOOK_LIMIT = 5'h00;
    localparam logic [4:0] RST_GK_PERIOD = 5'h00;

    // timing, in microseconds and derived frame counts
    localparam int FRAME_US = 125;
    localparam int HOOK_SAMPLE_US = 250;
    localparam int HOOK_STEP_US = 2000;
    localparam int GK_UNIT_US = 1000;
    localparam int FR_PER_SAMPLE = HOOK_SAMPLE_US / FRAME_US;
    localparam int FR_PER_STEP = HOOK_STEP_US / FRAME_US;
    localparam int FR_PER_MS = GK_UNIT_US / FRAME_US;
    localparam logic [2:0] GK_TOP = 3'h6;
    localparam logic [2:0] GK_BOTTOM = 3'h0;
endpackage : slic_pkg

// >>> hdl/slic_hook_filter.sv
// Purpose: switch-hook debounce filter for one channel
// Assumes: input already synchronised; ticks are one-cycle pulses
// Notes: output only moves on a 2 ms step tick
`timescale 1ns/100ps
`default_nettype none
module slic_hook_filter #(
    parameter int LIM_W = 5
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_sample_tick,
    input wire logic i_step_tick,
    input wire logic i_level,
    input wire logic [LIM_W-1:0] i_limit,
    output logic o_state
);
    import slic_pkg::*;

    logic last;
    logic [LIM_W-1:0] cnt;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            last <= 1'b0;
            cnt <= '0;
            o_state <= 1'b0;
        end else if (i_sample_tick && (i_level != last)) begin
            last <= i_level;
            cnt <= '0;
        end else if (i_step_tick && (last != o_state)) begin
            if (cnt >= i_limit) begin
                o_state <= last;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    a_hook_step_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_state != $past(o_state)) |-> $past(i_step_tick))
        else $error("hook state moved off a step tick");
    a_hook_limit_met: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_state != $past(o_state)) |-> ($past(cnt) >= $past(i_limit)))
        else $error("hook state moved before count reached");
endmodule // slic_hook_filter
`default_nettype wire

// >>> hdl/slic_gk_filter.sv
// Purpose: ground-key up/down debounce filter for one channel
// Assumes: i_ms_tick pulses once per millisecond
// Notes: a period of zero samples on every millisecond tick
`timescale 1ns/100ps
`default_nettype none
module slic_gk_filter #(
    parameter int PER_W = 5
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ms_tick,
    input wire logic i_level,
    input wire logic [PER_W-1:0] i_period,
    output logic o_state
);
    import slic_pkg::*;

    logic [PER_W-1:0] tmr;
    logic [2:0] cnt;
    logic gk_pulse;

    assign gk_pulse = i_ms_tick && (tmr >= i_period);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tmr <= '0;
        end else if (gk_pulse) begin
            tmr <= '0;
        end else if (i_ms_tick) begin
            tmr <= tmr + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= GK_BOTTOM;
        end else if (gk_pulse) begin
            if (i_level && (cnt != GK_TOP)) begin
                cnt <= cnt + 3'h1;
            end else if (!i_level && (cnt != GK_BOTTOM)) begin
                cnt <= cnt - 3'h1;
            end
        end
    end

    // latch holds between the bounds, so a mid-count wobble never shows
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_state <= 1'b0;
        end else if (cnt == GK_TOP) begin
            o_state <= 1'b1;
        end else if (cnt == GK_BOTTOM) begin
            o_state <= 1'b0;
        end
    end

    a_gk_count_bound: assert property (@(posedge i_core_clk) disable iff (i_rst)
        cnt <= GK_TOP)
        else $error("ground-key count above six");
    a_gk_latch_cause: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_state != $past(o_state)) |-> ($past(cnt) == (o_state ? GK_TOP : GK_BOTTOM)))
        else $error("ground-key latch moved between bounds");
endmodule // slic_gk_filter
`default_nettype wire

// >>> dv/slic_line_model.sv
// Purpose: line interface circuit model presenting levels on the channel input pins
// Assumes: the bench sets the level the line circuit puts on each pin
// Notes: a shared pin shows the device's value while the device drives it
`timescale 1ns/100ps
`default_nettype none
module slic_line_model (
    input wire logic [slic_pkg::NUM_CH-1:0] i_hook_level,
    input wire logic [slic_pkg::NUM_CH-1:0] i_gk_level,
    input wire logic [slic_pkg::NUM_CH-1:0] i_pin_a_level,
    input wire logic [slic_pkg::NUM_CH-1:0] i_pin_b_level,
    input wire logic [slic_pkg::NUM_CH-1:0] i_pin_a_dev,
    input wire logic [slic_pkg::NUM_CH-1:0] i_pin_a_oe,
    input wire logic [slic_pkg::NUM_CH-1:0] i_pin_b_dev,
    input wire logic [slic_pkg::NUM_CH-1:0] i_pin_b_oe,
    output logic [slic_pkg::NUM_CH-1:0] o_hook,
    output logic [slic_pkg::NUM_CH-1:0] o_gk,
    output logic [slic_pkg::NUM_CH-1:0] o_pin_a,
    output logic [slic_pkg::NUM_CH-1:0] o_pin_b
);
    import slic_pkg::*;
    assign o_hook = i_hook_level;
    assign o_gk = i_gk_level;
    // the line circuit backs off while the device drives, so no contention is modelled
    assign o_pin_a = (i_pin_a_oe & i_pin_a_dev) | (~i_pin_a_oe & i_pin_a_level);
    assign o_pin_b = (i_pin_b_oe & i_pin_b_dev) | (~i_pin_b_oe & i_pin_b_level);
endmodule // slic_line_model
`default_nettype wire

// >>> dv/slic_input_debounce_irq_tb.sv
// Purpose: self-checking bench for the line input debounce and interrupt block
// Assumes: frame strobe runs at 8 clocks a frame to shorten the debounce times
// Notes: expected times are derived from that shortened frame
`timescale 1ns/100ps
`default_nettype none
module slic_input_debounce_irq_tb;
    import slic_pkg::*;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] exp;
        logic err;
    } slic_row_s;
    logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic pready, pslverr, irq, rerr, fsync = 1'b0;
    logic [2:0] fs_cnt = 3'h0;
    logic [7:0] hook_lv = 8'h00, gk_lv = 8'h00, pa_lv = 8'h00, pb_lv = 8'h00;
    logic [7:0] hook_in, gk_in, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, deb_hook, deb_gk;
    int num_errors = 0, n_tests = 0, cycles = 0;
    slic_row_s rows [15] = '{
        '{1'b0, 8'h08, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h0C, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h14, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h18, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, 8'h08, 32'h0000_00FF, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h08, 32'h0000_0000, 32'h0000_00FF, 1'b0},
        '{1'b1, 8'h08, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, 8'h14, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h14, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0},
        '{1'b1, 8'h14, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, 8'h5C, 32'h0000_0A05, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h5C, 32'h0000_0000, 32'h0000_0A05, 1'b0},
        '{1'b0, 8'h1C, 32'h0000_0000, 32'h0000_0000, 1'b1},
        '{1'b1, 8'h03, 32'h0000_0001, 32'h0000_0000, 1'b1},
        '{1'b0, 8'h60, 32'h0000_0000, 32'h0000_0000, 1'b1}};

    slic_input_irq i_slic_input_irq (.i_core_clk(core_clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_frame_sync_strobe(fsync), .i_hook_input(hook_in), .i_ground_key_input(gk_in),
        .i_bidir_pin_a(pa_in), .o_bidir_pin_a(pa_out), .o_bidir_pin_a_oe(pa_oe),
        .i_bidir_pin_b(pb_in), .o_bidir_pin_b(pb_out), .o_bidir_pin_b_oe(pb_oe),
        .o_debounced_hook_bit(deb_hook), .o_debounced_ground_key_bit(deb_gk), .o_irq(irq));
    slic_line_model i_slic_line_model (.i_hook_level(hook_lv), .i_gk_level(gk_lv),
        .i_pin_a_level(pa_lv), .i_pin_b_level(pb_lv), .i_pin_a_dev(pa_out),
        .i_pin_a_oe(pa_oe), .i_pin_b_dev(pb_out), .i_pin_b_oe(pb_oe), .o_hook(hook_in),
        .o_gk(gk_in), .o_pin_a(pa_in), .o_pin_b(pb_in));

    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // one frame every 8 clocks: a 2 ms step becomes 128 clocks, a ms tick 64
    always @(posedge core_clk) begin
        fs_cnt <= fs_cnt + 3'h1;
        fsync <= fs_cnt[2];
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("Error t=%0t seen=%h expected=%h", $time, seen, exp);
            num_errors++;
        end
    endtask
    // waits on pready alone; the bench timeout ends a slave that never answers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rdat, exp);
    endtask
    function automatic logic probe(input int sel, input int ch);
        return (sel == 0) ? deb_hook[ch] : (sel == 1) ? deb_gk[ch] : irq;
    endfunction
    task automatic wait_for(input int sel, input int ch, input logic lvl, input int lim);
        int n;
        n = 0;
        while (probe(sel, ch) !== lvl && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        check({31'h0000_0000, probe(sel, ch)}, {31'h0000_0000, lvl});
    endtask

    initial begin
        int i;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check({15'h0000, irq, pa_oe, pb_oe}, 32'h0000_0000);
        for (i = 0; i < 15; i++) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            check({31'h0000_0000, rerr}, {31'h0000_0000, rows[i].err});
            if (rows[i].wr === 1'b0) check(rdat, rows[i].exp);
        end
        apb(1'b1, OFF_DIR_A, 32'h0000_0001);
        apb(1'b1, OFF_PIN_OUT, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        check({30'h0000_0000, pa_out[0], pa_oe[0]}, 32'h0000_0003);
        apb(1'b1, OFF_DIR_A, 32'h0000_0000);
        apb(1'b1, OFF_PIN_OUT, 32'h0000_0000);
        // hook limit 2: new level needs at least two full 2 ms steps
        apb(1'b1, 8'h40, 32'h0000_0002);
        apb(1'b1, OFF_IRQ_EN, 32'h0000_0001);
        hook_lv[0] <= 1'b1;
        repeat (200) @(posedge core_clk);
        check({31'h0000_0000, deb_hook[0]}, 32'h0000_0000);
        wait_for(0, 0, 1'b1, 600);
        wait_for(2, 0, 1'b1, 4);
        rd_chk(OFF_IRQ_PEND, 32'h0000_0001);
        rd_chk(OFF_HOOK_STAT, 32'h0000_0001);
        rd_chk(8'h20, 32'h0000_0011);
        rd_chk(OFF_IRQ_PEND, 32'h0000_0000);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        // ground key on channel 1 with its enable left off
        gk_lv[1] <= 1'b1;
        repeat (250) @(posedge core_clk);
        check({31'h0000_0000, deb_gk[1]}, 32'h0000_0000);
        wait_for(1, 1, 1'b1, 600);
        rd_chk(OFF_GK_STAT, 32'h0000_0002);
        rd_chk(OFF_IRQ_PEND, 32'h0000_0000);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        gk_lv[1] <= 1'b0;
        repeat (190) @(posedge core_clk);
        check({31'h0000_0000, deb_gk[1]}, 32'h0000_0001);
        wait_for(1, 1, 1'b0, 600);
        // shared pins on channel 2: no source while driven, raw while input
        apb(1'b1, OFF_DIR_B, 32'h0000_0004);
        apb(1'b1, OFF_IRQ_EN, 32'h0000_0C00);
        apb(1'b1, OFF_PIN_OUT, 32'h0000_0400);
        repeat (2) @(posedge core_clk);
        check({30'h0000_0000, pb_out[2], pb_oe[2]}, 32'h0000_0003);
        pb_lv[2] <= 1'b1;
        repeat (8) @(posedge core_clk);
        pb_lv[2] <= 1'b0;
        apb(1'b1, OFF_PIN_OUT, 32'h0000_0000);
        repeat (8) @(posedge core_clk);
        rd_chk(OFF_IRQ_PEND, 32'h0000_0000);
        apb(1'b1, OFF_DIR_B, 32'h0000_0000);
        pa_lv[2] <= 1'b1;
        pb_lv[2] <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd_chk(OFF_IRQ_PEND, 32'h0000_0C00);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        rd_chk(8'h28, 32'h0000_00CC);
        rd_chk(OFF_IRQ_PEND, 32'h0000_0000);
        end_of_test();
    end
endmodule // slic_input_debounce_irq_tb
`default_nettype wire
